// ---- itc_regs.sv ----
// configuration register bank and per-channel drive strobe sequencers
// What this block does; [RL5] is a duty of software
// [RL1] per-channel prefetch enable, bits 0 and 1
// [RL2] bit 3 picks one or zero wait states
// [RL3] bits 4-7 pick IORDY or DMA handshake
// [RL4] read-only write buffer occupancy per channel
// [RL5] software checks buffer empty before power-off
// [RL6] data port reads 16-bit, own read timing
// [RL7] data port writes 16-bit, own write timing
// [RL8] low nibble sets data strobe active time
// [RL9] high nibble sets data recovery time
// [RL10] command/control accesses 8-bit, shared timing
// [RL11] shared timing nibbles, reset value B7h
// [RL12] channel 1 sector size code, bits 3-0
// [RL13] channel 2 sector size, reset EEh
// [RL14] shadow captures last device control write
// [RL15] data timing registers reset to 85h
// [RL16] strobe active count then recovery count
// [RL17] shadow chosen by last selected drive
`timescale 1ns/100ps
module itc_regs (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic [7:0] CFG_ADDR,
  input  wire logic       CFG_WR,
  input  wire logic       CFG_RD,
  input  wire logic [7:0] CFG_WDATA,
  output logic      [7:0] CFG_RDATA,
  input  wire logic [1:0] WBUF_NOT_EMPTY,
  input  wire logic [1:0] DRV_REQ,
  input  wire logic [1:0] DRV_WRITE,
  input  wire logic [1:0] DRV_CTLBLK,
  input  wire logic [5:0] DRV_ADDR,
  input  wire logic [31:0] DRV_WDATA,
  output logic      [1:0] DRV_BUSY,
  output logic      [1:0] DRV_WIDE,
  output logic      [1:0] DRV_RD_STROBE,
  output logic      [1:0] DRV_WR_STROBE,
  output logic      [1:0] PREFETCH_EN,
  output logic            ZERO_WAIT,
  output logic      [3:0] FLOW_DMA_HANDSHAKE,
  output logic      [7:0] SECTOR_SIZE
);
  import itc_pkg::*;

  logic [7:0] ctl3_q;
  logic [7:0] rtim_q [4];
  logic [7:0] wtim_q [4];
  logic [7:0] cmdtim_q;
  logic [7:0] secsz_q;
  logic [7:0] shadow_q [4];
  logic [1:0] drv_sel_q;
  logic [1:0] wb_s1_q, wb_s2_q, wb_s3_q, wb_q;

  // index of a data timing register, -1 when the address is not one
  function automatic int tim_index(input logic [7:0] a);
    unique case (a)
      OFS_C1D1_RD, OFS_C1D1_WR: tim_index = 0;
      OFS_C1D2_RD, OFS_C1D2_WR: tim_index = 1;
      OFS_C2D1_RD, OFS_C2D1_WR: tim_index = 2;
      OFS_C2D2_RD, OFS_C2D2_WR: tim_index = 3;
      default:                  tim_index = -1;
    endcase
  endfunction

  // writable configuration registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctl3_q   <= RST_CTL3;
      cmdtim_q <= RST_CMDTIM;                  // [RL11]
      secsz_q  <= RST_SECSZ;                   // [RL13]
      for (int i = 0; i < 4; i++) begin
        rtim_q[i] <= RST_DATATIM;              // [RL15]
        wtim_q[i] <= RST_DATATIM;              // [RL15]
      end
    end else if (CFG_WR) begin
      if (CFG_ADDR == OFS_CTL3) ctl3_q <= CFG_WDATA & 8'hfb;  // bit 2 reserved
      if (CFG_ADDR == OFS_CMDTIM) cmdtim_q <= CFG_WDATA;
      if (CFG_ADDR == OFS_SECSZ) secsz_q <= CFG_WDATA;        // [RL12] [RL13]
      if (tim_index(CFG_ADDR) >= 0) begin
        if (CFG_ADDR[0]) wtim_q[tim_index(CFG_ADDR)] <= CFG_WDATA;
        else rtim_q[tim_index(CFG_ADDR)] <= CFG_WDATA;
      end
    end
  end

  // status pins come from outside; three stages, change taken when last two agree
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wb_s1_q <= 2'h0;
      wb_s2_q <= 2'h0;
      wb_s3_q <= 2'h0;
      wb_q    <= 2'h0;
    end else begin
      wb_s1_q <= WBUF_NOT_EMPTY;
      wb_s2_q <= wb_s1_q;
      wb_s3_q <= wb_s2_q;
      for (int c = 0; c < 2; c++)
        if (wb_s2_q[c] == wb_s3_q[c]) wb_q[c] <= wb_s3_q[c];  // [RL4]
    end
  end

  // register read mux; unmapped offsets read zero
  always_comb begin
    CFG_RDATA = 8'h00;
    if (CFG_RD) begin
      unique case (CFG_ADDR)
        OFS_CTL3:   CFG_RDATA = ctl3_q;
        OFS_WBSTAT: CFG_RDATA = {6'h00, wb_q};  // [RL4]
        OFS_CMDTIM: CFG_RDATA = cmdtim_q;
        OFS_SECSZ:  CFG_RDATA = secsz_q;
        OFS_C1_SH0: CFG_RDATA = shadow_q[0];
        OFS_C1_SH1: CFG_RDATA = shadow_q[1];
        OFS_C2_SH0: CFG_RDATA = shadow_q[2];
        OFS_C2_SH1: CFG_RDATA = shadow_q[3];
        default: begin
          if (tim_index(CFG_ADDR) >= 0)
            CFG_RDATA = CFG_ADDR[0] ? wtim_q[tim_index(CFG_ADDR)]
                                    : rtim_q[tim_index(CFG_ADDR)];
        end
      endcase
    end
  end

  // configuration outputs
  assign PREFETCH_EN        = {ctl3_q[BIT_PF_CH2], ctl3_q[BIT_PF_CH1]};  // [RL1]
  assign ZERO_WAIT          = ctl3_q[BIT_ZERO_WS];                       // [RL2]
  assign FLOW_DMA_HANDSHAKE = ctl3_q[BIT_FC_LO +: 4];                    // [RL3]
  assign SECTOR_SIZE        = secsz_q;

  // drive select tracking and device control shadows; shadows carry no
  // meaningful reset value but are cleared so simulation stays defined
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      drv_sel_q <= 2'h0;
      for (int i = 0; i < 4; i++) shadow_q[i] <= RST_SHADOW;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (DRV_REQ[c] && !DRV_BUSY[c] && DRV_WRITE[c]) begin
          if (!DRV_CTLBLK[c] && DRV_ADDR[3*c +: 3] == DRV_SELECT)
            drv_sel_q[c] <= DRV_WDATA[16*c + BIT_DRV_SEL];          // [RL17]
          if (DRV_CTLBLK[c])
            shadow_q[2*c + int'(drv_sel_q[c])] <= DRV_WDATA[16*c +: 8];  // [RL14] [RL17]
        end
      end
    end
  end

  // per-channel strobe sequencer
  itc_state_t st_q [2];
  logic [3:0] cnt_q [2];
  logic [3:0] rec_q [2];
  logic [1:0] wr_q;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int c = 0; c < 2; c++) begin
        st_q[c]  <= ST_IDLE;
        cnt_q[c] <= 4'h0;
        rec_q[c] <= 4'h0;
      end
      wr_q     <= 2'h0;
      DRV_WIDE <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        unique case (st_q[c])
          ST_IDLE: begin
            if (DRV_REQ[c]) begin
              logic [7:0] t;
              logic       data_port;
              data_port = !DRV_CTLBLK[c] && DRV_ADDR[3*c +: 3] == DRV_DATA;
              if (!data_port) t = cmdtim_q;                          // [RL10] [RL11]
              else if (DRV_WRITE[c]) t = wtim_q[2*c + int'(drv_sel_q[c])];  // [RL7]
              else t = rtim_q[2*c + int'(drv_sel_q[c])];                    // [RL6]
              DRV_WIDE[c] <= data_port;                              // [RL6] [RL7] [RL10]
              wr_q[c]     <= DRV_WRITE[c];
              cnt_q[c]    <= (t[3:0] == 4'h0) ? 4'h1 : t[3:0];      // [RL8] [RL11]
              rec_q[c]    <= t[7:4];                                 // [RL9]
              st_q[c]     <= ST_ACTIVE;
            end
          end
          ST_ACTIVE: begin
            if (cnt_q[c] == 4'h1) begin                              // [RL16]
              cnt_q[c] <= rec_q[c];
              st_q[c]  <= (rec_q[c] == 4'h0) ? ST_IDLE : ST_RECOVER;
            end else cnt_q[c] <= cnt_q[c] - 4'h1;
          end
          ST_RECOVER: begin
            if (cnt_q[c] == 4'h1) st_q[c] <= ST_IDLE;                // [RL16]
            else cnt_q[c] <= cnt_q[c] - 4'h1;
          end
          default: st_q[c] <= ST_IDLE;
        endcase
      end
    end
  end

  // strobes follow the active state directly; busy covers active and recovery
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      DRV_BUSY[c]      = st_q[c] != ST_IDLE;
      DRV_RD_STROBE[c] = st_q[c] == ST_ACTIVE && !wr_q[c];
      DRV_WR_STROBE[c] = st_q[c] == ST_ACTIVE && wr_q[c];
    end
  end
endmodule

// ---- itc_pkg.sv ----
// constants for the ide timing configuration register bank
package itc_pkg;
  localparam logic [7:0] OFS_CTL3    = 8'h42;
  localparam logic [7:0] OFS_WBSTAT  = 8'h43;
  localparam logic [7:0] OFS_C1D1_RD = 8'h44;
  localparam logic [7:0] OFS_C1D1_WR = 8'h45;
  localparam logic [7:0] OFS_C1D2_RD = 8'h48;
  localparam logic [7:0] OFS_C1D2_WR = 8'h49;
  localparam logic [7:0] OFS_C2D1_RD = 8'h4c;
  localparam logic [7:0] OFS_C2D1_WR = 8'h4d;
  localparam logic [7:0] OFS_C2D2_RD = 8'h50;
  localparam logic [7:0] OFS_C2D2_WR = 8'h51;
  localparam logic [7:0] OFS_CMDTIM  = 8'h54;
  localparam logic [7:0] OFS_SECSZ   = 8'h55;
  localparam logic [7:0] OFS_C1_SH0  = 8'h58;
  localparam logic [7:0] OFS_C1_SH1  = 8'h59;
  localparam logic [7:0] OFS_C2_SH0  = 8'h5c;
  localparam logic [7:0] OFS_C2_SH1  = 8'h5d;
  // reset values
  localparam logic [7:0] RST_CTL3    = 8'h00;
  localparam logic [7:0] RST_DATATIM = 8'h85;
  localparam logic [7:0] RST_CMDTIM  = 8'hb7;
  localparam logic [7:0] RST_SECSZ   = 8'hee;
  localparam logic [7:0] RST_SHADOW  = 8'h00;
  // field positions in control register three
  localparam int BIT_PF_CH1  = 0;
  localparam int BIT_PF_CH2  = 1;
  localparam int BIT_ZERO_WS = 3;
  localparam int BIT_FC_LO   = 4;
  // drive-side register offsets inside a channel window
  localparam logic [2:0] DRV_DATA    = 3'h0;
  localparam logic [2:0] DRV_SELECT  = 3'h6;
  localparam int         BIT_DRV_SEL = 4;
  // strobe sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ACTIVE  = 2'b01,
    ST_RECOVER = 2'b10
  } itc_state_t;
endpackage

// ---- itc_regs_properties.sv ----
// concurrent checks on the ide timing register bank ports
`timescale 1ns/100ps
module itc_regs_properties (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic [7:0] CFG_ADDR,
  input wire logic       CFG_WR,
  input wire logic [7:0] CFG_WDATA,
  input wire logic [7:0] CFG_RDATA,
  input wire logic [1:0] DRV_REQ,
  input wire logic [1:0] DRV_WRITE,
  input wire logic [1:0] DRV_BUSY,
  input wire logic [1:0] DRV_RD_STROBE,
  input wire logic [1:0] DRV_WR_STROBE,
  input wire logic [1:0] PREFETCH_EN,
  input wire logic       ZERO_WAIT,
  input wire logic [3:0] FLOW_DMA_HANDSHAKE,
  input wire logic [7:0] SECTOR_SIZE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // a config write lands one edge later; a taken drive request strobes one edge later
  sequence s_c3; CFG_WR && CFG_ADDR == 8'h42; endsequence
  sequence s_ss; CFG_WR && CFG_ADDR == 8'h55; endsequence
  sequence s_take; DRV_REQ[0] && !DRV_BUSY[0]; endsequence
  a_pf_follow: assert property (s_c3 |=> PREFETCH_EN == $past(CFG_WDATA[1:0]))
    else $error("prefetch bits wrong");
  a_wait_sel: assert property (s_c3 |=> ZERO_WAIT == $past(CFG_WDATA[3]))
    else $error("wait select wrong");
  a_flow_sel: assert property (s_c3 |=> FLOW_DMA_HANDSHAKE == $past(CFG_WDATA[7:4]))
    else $error("flow select wrong");
  a_sector_code: assert property (s_ss |=> SECTOR_SIZE == $past(CFG_WDATA))
    else $error("sector size wrong");
  a_status_rsvd: assert property (CFG_ADDR == 8'h43 |-> CFG_RDATA[7:2] == 6'h00)
    else $error("status reserved bits set");
  a_rd_take: assert property (s_take ##0 !DRV_WRITE[0] |=> DRV_RD_STROBE[0] && !DRV_WR_STROBE[0])
    else $error("read strobe missing");
  a_wr_take: assert property (s_take ##0 DRV_WRITE[0] |=> DRV_WR_STROBE[0] && !DRV_RD_STROBE[0])
    else $error("write strobe missing");
  a_strobe_busy: assert property (DRV_RD_STROBE[0] || DRV_WR_STROBE[0] |-> DRV_BUSY[0])
    else $error("strobe outside busy");
endmodule

// ---- itc_drive_model.sv ----
// drive-side model: measures how long the first channel's access strobe stays up
`timescale 1ns/100ps
module itc_drive_model (
  input  wire logic       clk,
  input  wire logic [1:0] rd_strobe,
  input  wire logic [1:0] wr_strobe,
  output logic      [7:0] act_len
);
  logic [7:0] run_q = 8'h00;
  // a drive only sees strobe edges, so the width is all it can judge
  // plain always: the counter starts from its declaration value, no reset pin here
  always @(posedge clk) begin
    if (rd_strobe[0] || wr_strobe[0]) begin
      run_q <= run_q + 8'h01;
    end else if (run_q != 8'h00) begin
      act_len <= run_q;
      run_q <= 8'h00;
    end
  end
endmodule

// ---- itc_regs_bench.sv ----
// self-checking bench for the ide timing register bank
`timescale 1ns/100ps
module itc_regs_bench;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CFG_WR = 1'b0;
  logic        CFG_RD = 1'b0;
  logic [7:0]  CFG_ADDR = 8'h00;
  logic [7:0]  CFG_WDATA = 8'h00;
  logic [1:0]  WBUF_NOT_EMPTY = 2'b00;
  logic [1:0]  DRV_REQ = 2'b00;
  logic [1:0]  DRV_WRITE = 2'b00;
  logic [1:0]  DRV_CTLBLK = 2'b00;
  logic [5:0]  DRV_ADDR = 6'h00;
  logic [31:0] DRV_WDATA = 32'h0000_0000;
  logic [7:0]  CFG_RDATA, SECTOR_SIZE, act_len;
  logic [1:0]  DRV_BUSY, DRV_WIDE, DRV_RD_STROBE, DRV_WR_STROBE, PREFETCH_EN;
  logic [3:0]  FLOW_DMA_HANDSHAKE;
  logic        ZERO_WAIT;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  itc_regs itc_regs_inst (.REF_CLK(REF_CLK), .RST(RST), .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .WBUF_NOT_EMPTY(WBUF_NOT_EMPTY),
    .DRV_REQ(DRV_REQ), .DRV_WRITE(DRV_WRITE), .DRV_CTLBLK(DRV_CTLBLK), .DRV_ADDR(DRV_ADDR),
    .DRV_WDATA(DRV_WDATA), .DRV_BUSY(DRV_BUSY), .DRV_WIDE(DRV_WIDE), .DRV_RD_STROBE(DRV_RD_STROBE),
    .DRV_WR_STROBE(DRV_WR_STROBE), .PREFETCH_EN(PREFETCH_EN), .ZERO_WAIT(ZERO_WAIT),
    .FLOW_DMA_HANDSHAKE(FLOW_DMA_HANDSHAKE), .SECTOR_SIZE(SECTOR_SIZE));
  itc_drive_model itc_drive_model_inst (.clk(REF_CLK), .rd_strobe(DRV_RD_STROBE),
    .wr_strobe(DRV_WR_STROBE), .act_len(act_len));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    CFG_ADDR <= a;
    CFG_WDATA <= d;
    CFG_WR <= 1'b1;
    @(posedge REF_CLK);
    CFG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge REF_CLK);
    CFG_ADDR <= a;
    CFG_RD <= 1'b1;
    @(negedge REF_CLK);
    chk(CFG_RDATA, e);
  endtask
  // one access on the first channel; t is the timing byte expected to govern it
  task automatic drv(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d,
                     input logic ew, input logic [7:0] t);
    logic [7:0] n;
    @(posedge REF_CLK);
    DRV_REQ[0] <= 1'b1;
    DRV_WRITE[0] <= w;
    DRV_CTLBLK[0] <= c;
    DRV_ADDR[2:0] <= a;
    DRV_WDATA[7:0] <= d;
    @(posedge REF_CLK);
    DRV_REQ[0] <= 1'b0;
    @(negedge REF_CLK);
    chk({7'h00, DRV_WIDE[0]}, {7'h00, ew});
    n = 8'h01;
    while (DRV_BUSY[0] === 1'b1 && n < 8'h28) begin
      @(negedge REF_CLK);
      n = n + 8'h01;
    end
    chk(n, {4'h0, t[3:0]} + {4'h0, t[7:4]} + 8'h01);
    chk(act_len, {4'h0, t[3:0]});
  endtask
  task automatic t_regs();
    rd(8'h42, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h44, 8'h85);
    rd(8'h51, 8'h85);
    rd(8'h54, 8'hb7);
    rd(8'h55, 8'hee);
    rd(8'h60, 8'h00);
    wr(8'h42, 8'hff);
    rd(8'h42, 8'hfb);
    chk({FLOW_DMA_HANDSHAKE, ZERO_WAIT, 1'b0, PREFETCH_EN}, 8'hfb);
    wr(8'h42, 8'h52);
    @(negedge REF_CLK);
    chk({FLOW_DMA_HANDSHAKE, ZERO_WAIT, 1'b0, PREFETCH_EN}, 8'h52);
    wr(8'h55, 8'h8c);
    rd(8'h55, 8'h8c);
    wr(8'h43, 8'hff);
    rd(8'h43, 8'h00);
    $display("register test done");
  endtask
  task automatic t_status();
    logic [1:0] v [3] = '{2'b01, 2'b10, 2'b00};
    for (int i = 0; i < 3; i++) begin
      @(posedge REF_CLK);
      WBUF_NOT_EMPTY <= v[i];
      repeat (6) @(posedge REF_CLK);
      rd(8'h43, {6'h00, v[i]});
    end
    $display("status test done");
  endtask
  task automatic t_drive();
    drv(1'b0, 1'b0, 3'h0, 8'h00, 1'b1, 8'h85);
    wr(8'h44, 8'h32);
    drv(1'b0, 1'b0, 3'h0, 8'h00, 1'b1, 8'h32);
    wr(8'h45, 8'h21);
    drv(1'b1, 1'b0, 3'h0, 8'h5a, 1'b1, 8'h21);
    drv(1'b0, 1'b0, 3'h1, 8'h00, 1'b0, 8'hb7);
    wr(8'h54, 8'h13);
    drv(1'b1, 1'b1, 3'h2, 8'h00, 1'b0, 8'h13);
    $display("drive timing test done");
  endtask
  task automatic t_shadow();
    drv(1'b1, 1'b0, 3'h6, 8'h10, 1'b0, 8'h13);
    drv(1'b0, 1'b0, 3'h0, 8'h00, 1'b1, 8'h85);
    drv(1'b1, 1'b1, 3'h2, 8'h0a, 1'b0, 8'h13);
    rd(8'h59, 8'h0a);
    rd(8'h58, 8'h00);
    drv(1'b1, 1'b0, 3'h6, 8'h00, 1'b0, 8'h13);
    drv(1'b1, 1'b1, 3'h2, 8'h04, 1'b0, 8'h13);
    rd(8'h58, 8'h04);
    $display("shadow test done");
  endtask
  // second channel: drive 1 data-port write under its own write timing
  task automatic t_chan2();
    int n;
    wr(8'h4d, 8'h12);
    @(posedge REF_CLK);
    DRV_REQ[1] <= 1'b1;
    DRV_WRITE[1] <= 1'b1;
    DRV_CTLBLK[1] <= 1'b0;
    DRV_ADDR[5:3] <= 3'h0;
    @(posedge REF_CLK);
    DRV_REQ[1] <= 1'b0;
    @(negedge REF_CLK);
    chk({5'h00, DRV_RD_STROBE[1], DRV_WR_STROBE[1], DRV_WIDE[1]}, 8'h03);
    n = 1;
    while (DRV_BUSY[1] === 1'b1 && n < 40) begin
      @(negedge REF_CLK);
      n++;
    end
    chk(8'(n), 8'h04);
    $display("second channel test done");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #4 REF_CLK = ~REF_CLK;
  end
  // a hang counts as a mismatch and closes the run
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    t_regs();
    t_status();
    t_drive();
    t_shadow();
    t_chan2();
    report_and_stop();
  end
endmodule
bind itc_regs itc_regs_properties itc_regs_properties_inst (.REF_CLK(REF_CLK), .RST(RST),
  .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
  .DRV_REQ(DRV_REQ), .DRV_WRITE(DRV_WRITE), .DRV_BUSY(DRV_BUSY), .DRV_RD_STROBE(DRV_RD_STROBE),
  .DRV_WR_STROBE(DRV_WR_STROBE), .PREFETCH_EN(PREFETCH_EN), .ZERO_WAIT(ZERO_WAIT),
  .FLOW_DMA_HANDSHAKE(FLOW_DMA_HANDSHAKE), .SECTOR_SIZE(SECTOR_SIZE));
